// ### src/dtd_decode.sv
// Purpose : decode data transfer instructions and time their execution
// Assumes : opcode, modrm and sib bytes arrive together with a start pulse
// Notes   : prefixes are decoded upstream; only addr32 is taken from them
`timescale 1ns/1ns
`default_nettype none

package dtd_pkg;

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_REAL = 2'h0;
  localparam logic [1:0] MODE_PROT = 2'h1;
  localparam logic [1:0] MODE_V86  = 2'h2;

  // ---------------------------------------------------------------
  // opcode values (low width bit masked where present)
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_ESCAPE   = 8'h0F;
  localparam logic [6:0] OPC_ST_RM    = 7'h44;  // 1000100w
  localparam logic [6:0] OPC_LD_RM    = 7'h45;  // 1000101w
  localparam logic [6:0] OPC_IMM_RM   = 7'h63;  // 1100011w
  localparam logic [3:0] OPC_IMM_REG  = 4'hB;   // 1011 w reg
  localparam logic [6:0] OPC_LD_ACC   = 7'h50;  // 1010000w
  localparam logic [6:0] OPC_ST_ACC   = 7'h51;  // 1010001w
  localparam logic [7:0] OPC_TO_SEG   = 8'h8E;
  localparam logic [7:0] OPC_FROM_SEG = 8'h8C;
  localparam logic [6:0] OPC_SEXT     = 7'h5F;  // 0F 1011111w
  localparam logic [6:0] OPC_ZEXT     = 7'h5B;  // 0F 1011011w
  localparam logic [7:0] OPC_GRP_FF   = 8'hFF;
  localparam logic [2:0] GRP_PUSH     = 3'h6;
  localparam logic [4:0] OPC_PUSH_REG = 5'h0A;  // 01010 reg
  localparam logic [4:0] OPC_POP_REG  = 5'h0B;  // 01011 reg
  localparam logic [2:0] OPC_SEG2_HI  = 3'h0;   // 000 ss 11x
  localparam logic [1:0] OPC_SEG2_LO  = 2'h3;
  localparam logic [1:0] OPC_SEG3_HI  = 2'h2;   // 0F 10 sss 00x
  localparam logic [1:0] OPC_SEG3_LO  = 2'h0;
  localparam logic [7:0] OPC_PUSH_IMM = 8'h68;  // 011010s0, s masked
  localparam logic [7:0] OPC_STK_ST   = 8'h60;
  localparam logic [7:0] OPC_STK_LD   = 8'h61;
  localparam logic [7:0] OPC_POP_RM   = 8'h8F;
  localparam logic [6:0] OPC_SWAP_RM  = 7'h43;  // 1000011w
  localparam logic [4:0] OPC_SWAP_ACC = 5'h12;  // 10010 reg
  localparam logic [6:0] OPC_IN_FIX   = 7'h72;
  localparam logic [6:0] OPC_IN_VAR   = 7'h76;
  localparam logic [6:0] OPC_OUT_FIX  = 7'h73;
  localparam logic [6:0] OPC_OUT_VAR  = 7'h77;
  localparam logic [7:0] OPC_EA_LOAD  = 8'h8D;
  localparam logic [2:0] SEG_LAST     = 3'h5;

  // ---------------------------------------------------------------
  // clock counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CLK_2   = 8'h02;
  localparam logic [7:0] CLK_3   = 8'h03;
  localparam logic [7:0] CLK_4   = 8'h04;
  localparam logic [7:0] CLK_5   = 8'h05;
  localparam logic [7:0] CLK_6   = 8'h06;
  localparam logic [7:0] CLK_7   = 8'h07;
  localparam logic [7:0] CLK_9   = 8'h09;
  localparam logic [7:0] CLK_10  = 8'h0A;
  localparam logic [7:0] CLK_11  = 8'h0B;
  localparam logic [7:0] CLK_12  = 8'h0C;
  localparam logic [7:0] CLK_13  = 8'h0D;
  localparam logic [7:0] CLK_18  = 8'h12;
  localparam logic [7:0] CLK_22  = 8'h16;
  localparam logic [7:0] CLK_23  = 8'h17;
  localparam logic [7:0] CLK_24  = 8'h18;
  localparam logic [7:0] CLK_25  = 8'h19;
  localparam logic [7:0] CLK_26  = 8'h1A;
  localparam logic [7:0] CLK_27  = 8'h1B;
  localparam logic [7:0] CLK_34  = 8'h22;
  localparam logic [7:0] CLK_40  = 8'h28;
  localparam logic [7:0] CLK_EA2 = 8'h01;
  localparam logic [7:0] CLK_WS  = 8'h01;

  typedef enum logic [4:0] {
    DTD_NONE, DTD_ST_RM, DTD_LD_RM, DTD_IMM_RM, DTD_IMM_REG, DTD_LD_ACC,
    DTD_ST_ACC, DTD_TO_SEG, DTD_FROM_SEG, DTD_SEXT, DTD_ZEXT, DTD_PUSH_RM,
    DTD_PUSH_REG, DTD_PUSH_SEG2, DTD_PUSH_SEG3, DTD_PUSH_IMM, DTD_STK_ST,
    DTD_POP_RM, DTD_POP_REG, DTD_POP_SEG2, DTD_POP_SEG3, DTD_STK_LD,
    DTD_SWAP_RM, DTD_SWAP_ACC, DTD_IN_FIX, DTD_IN_VAR, DTD_OUT_FIX,
    DTD_OUT_VAR, DTD_EA_LOAD
  } dtd_form_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } dtd_state_t;

endpackage : dtd_pkg

module dtd_decode
  import dtd_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_arst_n,
  input  wire logic       i_start,
  input  wire logic [7:0] i_op0,
  input  wire logic [7:0] i_op1,
  input  wire logic [7:0] i_modrm,
  input  wire logic [7:0] i_sib,
  input  wire logic       i_addr32,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_io_ok,
  input  wire logic [3:0] i_wait_states,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_valid,
  output logic            o_illegal,
  output logic [4:0]      o_form,
  output logic            o_byte_op,
  output logic            o_mem_op,
  output logic [3:0]      o_accesses,
  output logic [7:0]      o_clocks
);

  typedef struct packed {
    dtd_state_t state;
    logic       busy;
    logic       done;
    logic       valid;
    logic       illegal;
    dtd_form_t  form;
    logic       byte_op;
    logic       mem_op;
    logic [3:0] accesses;
    logic [7:0] clocks;
    logic [7:0] remain;
  } dtd_regs_t;

  dtd_regs_t r;
  dtd_regs_t next_r;

  logic ea_mem;
  logic ea_two_reg;

  dtd_ea_class u_ea (
    .i_modrm   (i_modrm),
    .i_sib     (i_sib),
    .i_addr32  (i_addr32),
    .o_is_mem  (ea_mem),
    .o_two_reg (ea_two_reg)
  );

  // ---------------------------------------------------------------
  // form recognition
  // ---------------------------------------------------------------
  function automatic dtd_form_t find_form(input logic [7:0] op0, input logic [7:0] op1,
                                          input logic [7:0] modrm);
    dtd_form_t f;
    f = DTD_NONE;
    if (op0 == OPC_ESCAPE) begin
      if (op1[7:1] == OPC_SEXT) f = DTD_SEXT;
      else if (op1[7:1] == OPC_ZEXT) f = DTD_ZEXT;
      else if (op1[7:6] == OPC_SEG3_HI && op1[2:1] == OPC_SEG3_LO)
        f = op1[0] ? DTD_POP_SEG3 : DTD_PUSH_SEG3;
    end
    else if (op0[7:1] == OPC_ST_RM) f = DTD_ST_RM;
    else if (op0[7:1] == OPC_LD_RM) f = DTD_LD_RM;
    else if (op0[7:1] == OPC_IMM_RM && modrm[5:3] == 3'h0) f = DTD_IMM_RM;
    else if (op0[7:4] == OPC_IMM_REG) f = DTD_IMM_REG;
    else if (op0[7:1] == OPC_LD_ACC) f = DTD_LD_ACC;
    else if (op0[7:1] == OPC_ST_ACC) f = DTD_ST_ACC;
    else if (op0 == OPC_TO_SEG) f = DTD_TO_SEG;
    else if (op0 == OPC_FROM_SEG) f = DTD_FROM_SEG;
    else if (op0 == OPC_GRP_FF && modrm[5:3] == GRP_PUSH) f = DTD_PUSH_RM;
    else if (op0[7:3] == OPC_PUSH_REG) f = DTD_PUSH_REG;
    else if (op0[7:3] == OPC_POP_REG) f = DTD_POP_REG;
    else if (op0[7:5] == OPC_SEG2_HI && op0[2:1] == OPC_SEG2_LO)
      f = op0[0] ? DTD_POP_SEG2 : DTD_PUSH_SEG2;
    else if ((op0 & 8'hFD) == OPC_PUSH_IMM) f = DTD_PUSH_IMM;
    else if (op0 == OPC_STK_ST) f = DTD_STK_ST;
    else if (op0 == OPC_STK_LD) f = DTD_STK_LD;
    else if (op0 == OPC_POP_RM && modrm[5:3] == 3'h0) f = DTD_POP_RM;
    else if (op0[7:1] == OPC_SWAP_RM) f = DTD_SWAP_RM;
    else if (op0[7:3] == OPC_SWAP_ACC) f = DTD_SWAP_ACC;
    else if (op0[7:1] == OPC_IN_FIX) f = DTD_IN_FIX;
    else if (op0[7:1] == OPC_IN_VAR) f = DTD_IN_VAR;
    else if (op0[7:1] == OPC_OUT_FIX) f = DTD_OUT_FIX;
    else if (op0[7:1] == OPC_OUT_VAR) f = DTD_OUT_VAR;
    else if (op0 == OPC_EA_LOAD) f = DTD_EA_LOAD;
    return f;
  endfunction : find_form

  // ---------------------------------------------------------------
  // listed clock count per form
  // ---------------------------------------------------------------
  // register count below memory count
  function automatic logic [7:0] pick(input logic mem, input logic [7:0] rc,
                                      input logic [7:0] mc);
    return mem ? mc : rc;
  endfunction : pick

  // listed counts are the unhindered minimum
  function automatic logic [7:0] base_clocks(input dtd_form_t f, input logic mem,
                                             input logic [1:0] mode, input logic io_ok);
    logic       prot;
    logic       v86;
    logic [7:0] c;
    prot = (mode == MODE_PROT);
    v86  = (mode == MODE_V86);
    c    = CLK_2;
    unique case (f)
      DTD_ST_RM:     c = CLK_2;
      DTD_LD_RM:     c = pick(mem, CLK_2, CLK_4);
      DTD_IMM_RM:    c = CLK_2;
      DTD_IMM_REG:   c = CLK_2;
      DTD_LD_ACC:    c = CLK_4;
      DTD_ST_ACC:    c = CLK_2;
      DTD_TO_SEG:    c = prot ? pick(mem, CLK_22, CLK_23) : pick(mem, CLK_2, CLK_5);
      DTD_FROM_SEG:  c = CLK_2;
      DTD_SEXT:      c = pick(mem, CLK_3, CLK_6);
      DTD_ZEXT:      c = pick(mem, CLK_3, CLK_6);
      DTD_PUSH_RM:   c = prot ? pick(mem, CLK_7, CLK_9) : pick(mem, CLK_5, CLK_7);
      DTD_PUSH_REG:  c = prot ? CLK_4 : CLK_2;
      DTD_PUSH_SEG2: c = prot ? CLK_4 : CLK_2;
      DTD_PUSH_SEG3: c = prot ? CLK_4 : CLK_2;
      DTD_PUSH_IMM:  c = prot ? CLK_4 : CLK_2;
      DTD_STK_ST:    c = prot ? CLK_34 : CLK_18;
      DTD_POP_RM:    c = prot ? pick(mem, CLK_7, CLK_9) : pick(mem, CLK_5, CLK_7);
      DTD_POP_REG:   c = CLK_6;
      DTD_POP_SEG2:  c = prot ? CLK_25 : CLK_7;
      DTD_POP_SEG3:  c = prot ? CLK_25 : CLK_7;
      DTD_STK_LD:    c = prot ? CLK_40 : CLK_24;
      DTD_SWAP_RM:   c = pick(mem, CLK_3, CLK_5);
      DTD_SWAP_ACC:  c = CLK_3;
      // in protected mode the privilege check decides the long count; virtual mode always takes it
      DTD_IN_FIX:    c = v86 ? CLK_26 : (prot ? (io_ok ? CLK_6 : CLK_26) : CLK_12);
      DTD_IN_VAR:    c = v86 ? CLK_27 : (prot ? (io_ok ? CLK_7 : CLK_27) : CLK_13);
      DTD_OUT_FIX:   c = v86 ? CLK_24 : (prot ? (io_ok ? CLK_4 : CLK_24) : CLK_10);
      DTD_OUT_VAR:   c = v86 ? CLK_25 : (prot ? (io_ok ? CLK_5 : CLK_25) : CLK_11);
      DTD_EA_LOAD:   c = CLK_2;
      default:       c = CLK_2;
    endcase
    return c;
  endfunction : base_clocks

  // ---------------------------------------------------------------
  // data accesses per form, used to charge wait states
  // ---------------------------------------------------------------
  function automatic logic [3:0] data_accesses(input dtd_form_t f, input logic mem);
    logic [3:0] n;
    n = 4'h0;
    unique case (f)
      DTD_ST_RM, DTD_LD_RM, DTD_IMM_RM, DTD_TO_SEG, DTD_FROM_SEG,
      DTD_SEXT, DTD_ZEXT:                      n = mem ? 4'h1 : 4'h0;
      DTD_LD_ACC, DTD_ST_ACC, DTD_PUSH_REG, DTD_PUSH_SEG2, DTD_PUSH_SEG3,
      DTD_PUSH_IMM, DTD_POP_REG, DTD_POP_SEG2, DTD_POP_SEG3,
      DTD_IN_FIX, DTD_IN_VAR, DTD_OUT_FIX, DTD_OUT_VAR: n = 4'h1;
      DTD_PUSH_RM, DTD_POP_RM:                  n = mem ? 4'h2 : 4'h1;
      DTD_STK_ST, DTD_STK_LD:                   n = 4'h8;
      DTD_SWAP_RM:                              n = mem ? 4'h2 : 4'h0;
      DTD_EA_LOAD:                              n = 4'h0;
      default:                                  n = 4'h0;
    endcase
    return n;
  endfunction : data_accesses

  // ---------------------------------------------------------------
  // decode of the presented instruction
  // ---------------------------------------------------------------
  dtd_form_t  d_form;
  logic       d_modrm;
  logic       d_mem;
  logic       d_bad_seg;
  logic       d_byte;
  logic [3:0] d_acc;
  logic [8:0] d_total;

  always_comb begin
    d_form    = find_form(i_op0, i_op1, i_modrm);
    d_modrm   = (d_form inside {DTD_ST_RM, DTD_LD_RM, DTD_IMM_RM, DTD_TO_SEG, DTD_FROM_SEG,
                                DTD_SEXT, DTD_ZEXT, DTD_PUSH_RM, DTD_POP_RM, DTD_SWAP_RM,
                                DTD_EA_LOAD});
    d_mem     = d_modrm && ea_mem;
    d_mem     = d_mem || (d_form inside {DTD_LD_ACC, DTD_ST_ACC});
    // only six segment registers exist; codes above are refused
    d_bad_seg = ((d_form inside {DTD_TO_SEG, DTD_FROM_SEG}) && (i_modrm[5:3] > SEG_LAST))
             || ((d_form inside {DTD_PUSH_SEG3, DTD_POP_SEG3}) && (i_op1[5:3] > SEG_LAST));
    d_byte    = 1'b0;
    if (d_form == DTD_IMM_REG) begin
      d_byte = ~i_op0[3];
    end else if (d_form inside {DTD_SEXT, DTD_ZEXT}) begin
      d_byte = ~i_op1[0];
    end else if (d_form inside {DTD_ST_RM, DTD_LD_RM, DTD_IMM_RM, DTD_LD_ACC, DTD_ST_ACC,
                                DTD_SWAP_RM, DTD_IN_FIX, DTD_IN_VAR, DTD_OUT_FIX,
                                DTD_OUT_VAR}) begin
      d_byte = ~i_op0[0];
    end
    d_acc     = data_accesses(d_form, d_mem);
    d_total   = {1'b0, base_clocks(d_form, d_mem, i_mode, i_io_ok)};
    // base plus index costs one more
    // only forms with a modrm byte form an address; short forms carry a full displacement
    if (d_modrm && d_mem && ea_two_reg) begin
      d_total = d_total + {1'b0, CLK_EA2};
    end
    // one clock per wait state per access
    d_total = d_total + 9'(d_acc * i_wait_states * CLK_WS);
  end

  // ---------------------------------------------------------------
  // execution sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    unique case (r.state)
      ST_IDLE: begin
        if (i_start) begin
          next_r.form     = d_form;
          next_r.byte_op  = d_byte;
          next_r.mem_op   = d_mem;
          next_r.accesses = d_acc;
          if (d_form == DTD_NONE || d_bad_seg) begin
            // unknown forms finish at once with no clocks charged
            next_r.valid   = 1'b0;
            next_r.illegal = 1'b1;
            next_r.clocks  = 8'h00;
            next_r.remain  = 8'h00;
            next_r.state   = ST_DONE;
            next_r.done    = 1'b1;
          end else begin
            next_r.valid   = 1'b1;
            next_r.illegal = 1'b0;
            next_r.clocks  = d_total[7:0];
            next_r.remain  = d_total[7:0] - 8'h01;
            next_r.state   = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (r.remain == 8'h00) begin
          next_r.state = ST_DONE;
          next_r.done  = 1'b1;
        end else begin
          next_r.remain = r.remain - 8'h01;
        end
      end
      ST_DONE: begin
        next_r.state = ST_IDLE;
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
    next_r.busy = (next_r.state == ST_EXEC);
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r <= '{state: ST_IDLE, form: DTD_NONE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign o_busy     = r.busy;
  assign o_done     = r.done;
  assign o_valid    = r.valid;
  assign o_illegal  = r.illegal;
  assign o_form     = r.form;
  assign o_byte_op  = r.byte_op;
  assign o_mem_op   = r.mem_op;
  assign o_accesses = r.accesses;
  assign o_clocks   = r.clocks;

endmodule : dtd_decode

`default_nettype wire

// ### src/dtd_ea_class.sv
// Purpose : classify the operand addressed by a modrm byte (and sib byte)
// Assumes : modrm and sib come from logic on the same clock; purely combinational
// Notes   : mod = 11 selects a register operand, anything else a memory operand
`timescale 1ns/1ns
`default_nettype none

module dtd_ea_class (
  input  wire logic [7:0] i_modrm,
  input  wire logic [7:0] i_sib,
  input  wire logic       i_addr32,
  output logic            o_is_mem,
  output logic            o_two_reg
);

  logic [1:0] mod_f;
  logic [2:0] rm_f;
  logic [2:0] idx_f;
  logic [2:0] base_f;

  assign mod_f  = i_modrm[7:6];
  assign rm_f   = i_modrm[2:0];
  assign idx_f  = i_sib[5:3];
  assign base_f = i_sib[2:0];

  // ---------------------------------------------------------------
  // operand kind and base plus index detection
  // ---------------------------------------------------------------
  always_comb begin
    o_is_mem  = (mod_f != 2'b11);
    o_two_reg = 1'b0;
    if (o_is_mem) begin
      if (!i_addr32) begin
        // 16-bit forms 000..011 add two registers together
        o_two_reg = (rm_f[2] == 1'b0);
      end else if (rm_f == 3'b100) begin
        // index 100 means no index; mod 00 with base 101 means no base
        o_two_reg = (idx_f != 3'b100) && !((mod_f == 2'b00) && (base_f == 3'b101));
      end
    end
  end

endmodule : dtd_ea_class

`default_nettype wire

// ### verif/dtd_decode_chk_sva.sv
// Purpose : port-level timing checks for dtd_decode
// Assumes : single clock, asynchronous active-low reset
// Notes   : exact counts are pinned where no wait charge can creep in, and with the wait charge added for the accumulator load
`timescale 1ns/1ns
`default_nettype none

module dtd_decode_chk
  import dtd_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_arst_n,
  input wire logic       i_start,
  input wire logic [7:0] i_op0,
  input wire logic [7:0] i_op1,
  input wire logic [7:0] i_modrm,
  input wire logic [7:0] i_sib,
  input wire logic       i_addr32,
  input wire logic [1:0] i_mode,
  input wire logic       i_io_ok,
  input wire logic [3:0] i_wait_states,
  input wire logic       o_busy,
  input wire logic       o_done,
  input wire logic       o_valid,
  input wire logic       o_illegal,
  input wire logic [4:0] o_form,
  input wire logic       o_byte_op,
  input wire logic       o_mem_op,
  input wire logic [3:0] o_accesses,
  input wire logic [7:0] o_clocks
);
  logic [7:0] busy_cnt;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // busy span is counted here so it can be held against the reported count
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) busy_cnt <= 8'h00;
    else busy_cnt <= o_busy ? busy_cnt + 8'h01 : 8'h00;
  end

  // ----------------
  // assertions
  // ----------------
  sequence s_take;
    i_start && !o_busy && !o_done;
  endsequence

  sequence s_take_nw;
    s_take ##0 (i_wait_states == 4'h0);
  endsequence

  chk_busy_span: assert property ($fell(o_busy) |-> busy_cnt == o_clocks)
    else $error("busy span differs from clock count");
  chk_done_after: assert property ($fell(o_busy) |-> o_done)
    else $error("done missing after busy");
  chk_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  chk_illegal_fast: assert property (s_take ##1 o_illegal |-> o_done && !o_busy)
    else $error("unknown opcode not finished at once");
  chk_short_imm: assert property (s_take ##0 (i_op0[7:4] == 4'hB) |=>
    o_clocks == CLK_2 && o_byte_op == !$past(i_op0[3]))
    else $error("short immediate load count or width wrong");
  chk_swap_acc: assert property (s_take ##0 (i_op0[7:3] == OPC_SWAP_ACC) |=>
    o_clocks == CLK_3)
    else $error("accumulator swap count wrong");
  chk_ea_load: assert property (s_take ##0 (i_op0 == OPC_EA_LOAD) |=>
    o_clocks == CLK_2 && o_accesses == 4'h0)
    else $error("address load count wrong");
  chk_acc_wait: assert property (s_take ##0 (i_op0[7:1] == OPC_LD_ACC) |=>
    o_clocks == CLK_4 + {4'h0, $past(i_wait_states)})
    else $error("accumulator load wait charge wrong");
  chk_seg_pop: assert property (s_take_nw ##0 (i_op0[7:5] == 3'h0 && i_op0[2:0] == 3'h7
    && i_op0 != OPC_ESCAPE) |=> o_clocks == (($past(i_mode) == MODE_PROT) ? CLK_25 : CLK_7))
    else $error("short segment pop count wrong");
  chk_port_v86: assert property (s_take_nw ##0 (i_op0[7:1] == OPC_IN_FIX
    && i_mode == MODE_V86) |=> o_clocks == CLK_26)
    else $error("fixed port input count wrong in virtual mode");

endmodule : dtd_decode_chk

`default_nettype wire

// ### verif/data_transfer_decode_timing_test.sv
// Purpose : directed scenarios for the data transfer decoder
// Assumes : inputs change on the falling clock edge
// Notes   : wait charges follow the access counts chosen for each form
`timescale 1ns/1ns
`default_nettype none

module data_transfer_decode_timing_test import dtd_pkg::*;;
  logic       mclk, arst_n = 1'b0, start = 1'b0, addr32 = 1'b0, io_ok = 1'b0, poke = 1'b0;
  logic [7:0] op0 = 8'h00, op1 = 8'h00, modrm = 8'h00, sib = 8'h00;
  logic [1:0] mode = 2'h0;
  logic [3:0] wait_states = 4'h0;
  logic       busy, done, valid, illegal, byte_op, mem_op;
  logic [4:0] form;
  logic [3:0] accesses;
  logic [7:0] clocks;
  int         err_count = 0, compares = 0, cycles = 0;

  dtd_decode uut (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_start(start), .i_op0(op0), .i_op1(op1),
    .i_modrm(modrm), .i_sib(sib), .i_addr32(addr32), .i_mode(mode), .i_io_ok(io_ok),
    .i_wait_states(wait_states), .o_busy(busy), .o_done(done), .o_valid(valid),
    .o_illegal(illegal), .o_form(form), .o_byte_op(byte_op), .o_mem_op(mem_op),
    .o_accesses(accesses), .o_clocks(clocks)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------
  // shared tasks
  // ----------------
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // runs one instruction; a poke raises a start mid-busy that must be ignored
  task automatic op(input logic [7:0] p0, input logic [7:0] p1, input logic [7:0] m,
                    input logic [1:0] md, input logic [3:0] ws, input logic [7:0] ck,
                    input dtd_form_t fm);
    int n;
    n = 0;
    @(negedge mclk);
    op0 = p0;
    op1 = p1;
    modrm = m;
    mode = md;
    wait_states = ws;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    cmp(clocks, ck);
    cmp({3'h0, form}, {3'h0, fm});
    cmp({6'h00, valid, illegal}, {6'h00, ck != 8'h00, ck == 8'h00});
    while (busy === 1'b1 && n < 300) begin
      n++;
      start = poke && n == 2;
      op0 = poke ? 8'hD6 : p0;
      @(negedge mclk);
    end
    start = 1'b0;
    cmp(8'(n), ck);
    cmp({7'h00, done}, 8'h01);
    @(negedge mclk);
    cmp({7'h00, done}, 8'h00);
  endtask : op

  // ----------------
  // scenarios
  // ----------------
  task automatic t_moves;
    op(8'h8B, 8'h00, 8'hC0, 2'h0, 4'h0, 8'h02, DTD_LD_RM);
    cmp({7'h00, mem_op}, 8'h00);
    op(8'h8A, 8'h00, 8'h06, 2'h0, 4'h3, 8'h07, DTD_LD_RM);
    cmp({3'h0, byte_op, accesses}, 8'h11);
    cmp({7'h00, mem_op}, 8'h01);
    op(8'h8B, 8'h00, 8'h00, 2'h0, 4'h0, 8'h05, DTD_LD_RM);
    op(8'h89, 8'h00, 8'h00, 2'h1, 4'h2, 8'h05, DTD_ST_RM);
    op(8'h88, 8'h00, 8'hC3, 2'h1, 4'h0, 8'h02, DTD_ST_RM);
    op(8'hA1, 8'h00, 8'h00, 2'h1, 4'h1, 8'h05, DTD_LD_ACC);
    op(8'hA3, 8'h00, 8'h00, 2'h0, 4'h0, 8'h02, DTD_ST_ACC);
    op(8'hB8, 8'h00, 8'h00, 2'h1, 4'h0, 8'h02, DTD_IMM_REG);
    cmp({7'h00, byte_op}, 8'h00);
    op(8'h8C, 8'h00, 8'h06, 2'h1, 4'h0, 8'h02, DTD_FROM_SEG);
  endtask : t_moves

  task automatic t_seg;
    op(8'h8E, 8'h00, 8'hD8, 2'h0, 4'h0, 8'h02, DTD_TO_SEG);
    op(8'h8E, 8'h00, 8'hD8, 2'h1, 4'h0, 8'h16, DTD_TO_SEG);
    op(8'h8E, 8'h00, 8'h1E, 2'h0, 4'h0, 8'h05, DTD_TO_SEG);
    op(8'h8E, 8'h00, 8'h1E, 2'h1, 4'h0, 8'h17, DTD_TO_SEG);
    op(8'h8E, 8'h00, 8'hF0, 2'h0, 4'h0, 8'h00, DTD_TO_SEG);
    for (int s = 0; s < 6; s++) begin
      op(8'h0F, {2'h2, 3'(s), 3'h0}, 8'h00, 2'h1, 4'h0, 8'h04, DTD_PUSH_SEG3);
      op(8'h0F, {2'h2, 3'(s), 3'h1}, 8'h00, 2'h0, 4'h0, 8'h07, DTD_POP_SEG3);
    end
    op(8'h0F, 8'hA0, 8'h00, 2'h0, 4'h0, 8'h02, DTD_PUSH_SEG3);
    op(8'h0F, 8'hA9, 8'h00, 2'h1, 4'h0, 8'h19, DTD_POP_SEG3);
    op(8'h0F, 8'hB0, 8'h00, 2'h0, 4'h0, 8'h00, DTD_PUSH_SEG3);
    // the code-segment pop shares its byte with the escape, so it is skipped
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        op({3'h0, 2'(s), 3'h7}, 8'h00, 8'h00, 2'h1, 4'h0, 8'h19, DTD_POP_SEG2);
        op({3'h0, 2'(s), 3'h7}, 8'h00, 8'h00, 2'h2, 4'h0, 8'h07, DTD_POP_SEG2);
      end
    end
  endtask : t_seg

  task automatic t_ext;
    op(8'h0F, 8'hBE, 8'hC0, 2'h0, 4'h0, 8'h03, DTD_SEXT);
    op(8'h0F, 8'hBF, 8'h06, 2'h1, 4'h2, 8'h08, DTD_SEXT);
    op(8'h0F, 8'hB6, 8'hC0, 2'h1, 4'h0, 8'h03, DTD_ZEXT);
    op(8'h0F, 8'hB7, 8'h06, 2'h0, 4'h0, 8'h06, DTD_ZEXT);
    op(8'hFF, 8'h00, 8'hF0, 2'h1, 4'h0, 8'h07, DTD_PUSH_RM);
    op(8'hFF, 8'h00, 8'h36, 2'h0, 4'h1, 8'h09, DTD_PUSH_RM);
    op(8'hFF, 8'h00, 8'h36, 2'h1, 4'h0, 8'h09, DTD_PUSH_RM);
  endtask : t_ext

  task automatic t_swap;
    op(8'h87, 8'h00, 8'hC1, 2'h0, 4'h0, 8'h03, DTD_SWAP_RM);
    op(8'h86, 8'h00, 8'h07, 2'h1, 4'h1, 8'h07, DTD_SWAP_RM);
    for (int r = 0; r < 8; r++) begin
      op({5'h12, 3'(r)}, 8'h00, 8'h00, 2'(r % 3), 4'h0, 8'h03, DTD_SWAP_ACC);
    end
  endtask : t_swap

  task automatic t_port;
    op(8'hE4, 8'h00, 8'h00, 2'h0, 4'h0, 8'h0C, DTD_IN_FIX);
    io_ok = 1'b1;
    op(8'hE5, 8'h00, 8'h00, 2'h1, 4'h0, 8'h06, DTD_IN_FIX);
    io_ok = 1'b0;
    op(8'hE5, 8'h00, 8'h00, 2'h1, 4'h0, 8'h1A, DTD_IN_FIX);
    op(8'hE4, 8'h00, 8'h00, 2'h2, 4'h0, 8'h1A, DTD_IN_FIX);
  endtask : t_port

  task automatic t_ea;
    op(8'h8D, 8'h00, 8'h06, 2'h1, 4'h5, 8'h02, DTD_EA_LOAD);
    cmp({4'h0, accesses}, 8'h00);
    addr32 = 1'b1;
    sib = 8'h18;
    op(8'h8B, 8'h00, 8'h04, 2'h0, 4'h0, 8'h05, DTD_LD_RM);
    sib = 8'h20;
    op(8'h8B, 8'h00, 8'h04, 2'h0, 4'h0, 8'h04, DTD_LD_RM);
    addr32 = 1'b0;
  endtask : t_ea

  task automatic t_refuse;
    poke = 1'b1;
    op(8'h8B, 8'h00, 8'hC0, 2'h0, 4'h0, 8'h02, DTD_LD_RM);
    poke = 1'b0;
    cmp({2'h0, illegal, form}, {3'h0, DTD_LD_RM});
    op(8'hD6, 8'h00, 8'h00, 2'h0, 4'h0, 8'h00, DTD_NONE);
  endtask : t_refuse

  // ----------------
  // run control
  // ----------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    t_moves();
    t_seg();
    t_ext();
    t_swap();
    t_port();
    t_ea();
    t_refuse();
    conclude();
  end

endmodule : data_transfer_decode_timing_test

bind dtd_decode dtd_decode_chk chk_i (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_start(i_start), .i_op0(i_op0), .i_op1(i_op1),
  .i_modrm(i_modrm), .i_sib(i_sib), .i_addr32(i_addr32), .i_mode(i_mode),
  .i_io_ok(i_io_ok), .i_wait_states(i_wait_states), .o_busy(o_busy), .o_done(o_done),
  .o_valid(o_valid), .o_illegal(o_illegal), .o_form(o_form), .o_byte_op(o_byte_op),
  .o_mem_op(o_mem_op), .o_accesses(o_accesses), .o_clocks(o_clocks)
);

`default_nettype wire
